// [hw/exposure_gain_consts.svh]
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: Bit 0 of the register map is the word MSB (bit 31 here)
// Notes:   Value field bits 20..31 map to [11:0]
//
// Overview of operation
// - Feature-present flag reads 1 in both registers, read only
// - Absolute-control flag reads 0; value field alone controls the feature
// - Single-shot auto flag reads 0; writes never start it
// - On/off flag reads 1; feature cannot be switched off
// - Auto/manual flag reads 0 meaning manual; read only
// - Exposure value in bits 20-31; software writes only 1 to 4095
// - Exposure value resets to 500; duration is value times time base
// - Time base defaults to 20 us; a separate setting may scale it
// - Gain value in bits 20-31; 8-bit or YUV formats allow 350 to 1023
// - 16-bit mono or raw formats allow gain 350 to 511
// - Gain resets to 370; setting 350 gives unity gain, 0 dB
// - Gain setting 1023 gives 25.9 dB, twenty times
`ifndef EXPOSURE_GAIN_CONSTS_SVH
`define EXPOSURE_GAIN_CONSTS_SVH

`define EXPOSURE_CONTROL_OFS 12'h81c
`define GAIN_CONTROL_OFS     12'h820

`define PRESENT_BIT   31
`define ABS_BIT       30
`define ONE_PUSH_BIT  26
`define ON_OFF_BIT    25
`define AUTO_BIT      24
`define VALUE_MSB     11
`define VALUE_LSB     0

`define EXPOSURE_RESET 12'h1f4
`define GAIN_RESET     12'h172
`define EXPOSURE_MIN   12'h001
`define GAIN_MIN       12'h15e
`define GAIN_MAX_NARROW 12'h3ff
`define GAIN_MAX_WIDE  12'h1ff
`define GAIN_DB_SPAN   9'h103
`define GAIN_CODE_SPAN 10'h2a1

`define CLK_PERIOD_NS  10
`define TIME_BASE_US   20
`define TIME_BASE_CYC  (`TIME_BASE_US * 1000 / `CLK_PERIOD_NS)

`endif

// [hw/exposure_gain_pkg.sv]
// Purpose: Shared types for the exposure and gain feature registers
// Assumes: Constants come from exposure_gain_consts.svh
// Notes:   Register requests carried as one packed struct
`default_nettype none
package exposure_gain_pkg;

  typedef struct packed {
    logic [11:0] addr;
    logic        wr;
    logic        rd;
    logic [31:0] wdata;
  } reg_req_t;

  typedef enum logic [0:0] {
    EXP_IDLE,
    EXP_RUN
  } exp_state_t;

endpackage : exposure_gain_pkg
`default_nettype wire

// [hw/exposure_gain_feature_csrs.sv]
// Purpose: Exposure and gain feature registers with exposure timer
// Assumes: Register requests synchronous to ref_clk_i, one per cycle
// Notes:   Read data returns one cycle after the read strobe
`timescale 1ns/10ps
`default_nettype none
`include "exposure_gain_consts.svh"

module exposure_gain_feature_csrs
  import exposure_gain_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  // Register port
  input  wire reg_req_t    reg_req_i,
  output var  logic [31:0] reg_rdata_o,
  output var  logic        reg_rvalid_o,
  // Capture control
  input  wire logic        frame_start_i,
  input  wire logic        wide_format_i,
  input  wire logic [7:0]  tb_mult_i,
  // Capture outputs
  output var  logic        exposing_o,
  output var  logic        exposure_done_o,
  output var  logic [11:0] gain_applied_o,
  output var  logic [8:0]  gain_db_x10_o,
  output var  logic        exp_range_err_o,
  output var  logic        gain_range_err_o
);

  localparam logic [11:0] TB_LAST = 12'(`TIME_BASE_CYC - 1);

  // Fixed capability flags with value field
  function automatic logic [31:0] feature_word(input logic [11:0] val);
    logic [31:0] w;
    w                                 = 32'h0000_0000;
    w[`PRESENT_BIT]                   = 1'b1;
    w[`ABS_BIT]                       = 1'b0;
    w[`ONE_PUSH_BIT]                  = 1'b0;
    w[`ON_OFF_BIT]                    = 1'b1;
    w[`AUTO_BIT]                      = 1'b0;
    w[`VALUE_MSB:`VALUE_LSB]          = val;
    return w;
  endfunction : feature_word

  // Register file state
  logic [11:0] exp_val_reg;
  logic [11:0] exp_val_next;
  logic [11:0] gain_val_reg;
  logic [11:0] gain_val_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        rvalid_reg;
  logic        rvalid_next;

  always_comb begin
    exp_val_next  = exp_val_reg;
    gain_val_next = gain_val_reg;
    rdata_next    = 32'h0000_0000;
    rvalid_next   = reg_req_i.rd;
    if (reg_req_i.wr) begin
      if (reg_req_i.addr == `EXPOSURE_CONTROL_OFS) begin
        exp_val_next = reg_req_i.wdata[`VALUE_MSB:`VALUE_LSB];
      end
      if (reg_req_i.addr == `GAIN_CONTROL_OFS) begin
        gain_val_next = reg_req_i.wdata[`VALUE_MSB:`VALUE_LSB];
      end
    end
    if (reg_req_i.rd) begin
      if (reg_req_i.addr == `EXPOSURE_CONTROL_OFS) begin
        rdata_next = feature_word(exp_val_reg);
      end else if (reg_req_i.addr == `GAIN_CONTROL_OFS) begin
        rdata_next = feature_word(gain_val_reg);
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      exp_val_reg  <= `EXPOSURE_RESET;
      gain_val_reg <= `GAIN_RESET;
      rdata_reg    <= 32'h0000_0000;
      rvalid_reg   <= 1'b0;
    end else begin
      exp_val_reg  <= exp_val_next;
      gain_val_reg <= gain_val_next;
      rdata_reg    <= rdata_next;
      rvalid_reg   <= rvalid_next;
    end
  end

  assign reg_rdata_o  = rdata_reg;
  assign reg_rvalid_o = rvalid_reg;

  // Exposure timer and per-frame latch
  exp_state_t  state_reg;
  exp_state_t  state_next;
  logic [11:0] tb_cnt_reg;
  logic [11:0] tb_cnt_next;
  logic [19:0] units_reg;
  logic [19:0] units_next;
  logic        exposing_reg;
  logic        exposing_next;
  logic        done_reg;
  logic        done_next;
  logic [11:0] gain_app_reg;
  logic [11:0] gain_app_next;
  logic [8:0]  gain_db_reg;
  logic [8:0]  gain_db_next;
  logic        exp_err_reg;
  logic        exp_err_next;
  logic        gain_err_reg;
  logic        gain_err_next;
  logic [11:0] exp_eff;
  logic [7:0]  mult_eff;
  logic [11:0] gain_max;
  logic [11:0] gain_clamped;
  logic [20:0] db_prod;

  always_comb begin
    exp_eff  = (exp_val_reg < `EXPOSURE_MIN) ? `EXPOSURE_MIN : exp_val_reg;
    mult_eff = (tb_mult_i == 8'h00) ? 8'h01 : tb_mult_i;
    gain_max = wide_format_i ? `GAIN_MAX_WIDE : `GAIN_MAX_NARROW;
    if (gain_val_reg < `GAIN_MIN) begin
      gain_clamped = `GAIN_MIN;
    end else if (gain_val_reg > gain_max) begin
      gain_clamped = gain_max;
    end else begin
      gain_clamped = gain_val_reg;
    end
    db_prod       = 21'(gain_app_reg - `GAIN_MIN) * 21'(`GAIN_DB_SPAN);
    gain_db_next  = 9'(db_prod / 21'(`GAIN_CODE_SPAN));
    state_next    = state_reg;
    tb_cnt_next   = tb_cnt_reg;
    units_next    = units_reg;
    exposing_next = exposing_reg;
    done_next     = 1'b0;
    gain_app_next = gain_app_reg;
    exp_err_next  = exp_err_reg;
    gain_err_next = gain_err_reg;
    case (state_reg)
      EXP_IDLE: begin
        if (frame_start_i) begin
          state_next    = EXP_RUN;
          tb_cnt_next   = 12'h000;
          units_next    = 20'(exp_eff * mult_eff);
          exposing_next = 1'b1;
          gain_app_next = gain_clamped;
          exp_err_next  = (exp_val_reg < `EXPOSURE_MIN);
          gain_err_next = (gain_clamped != gain_val_reg);
        end
      end
      EXP_RUN: begin
        if (tb_cnt_reg == TB_LAST) begin
          tb_cnt_next = 12'h000;
          if (units_reg == 20'h00001) begin
            state_next    = EXP_IDLE;
            exposing_next = 1'b0;
            done_next     = 1'b1;
          end else begin
            units_next = units_reg - 20'h00001;
          end
        end else begin
          tb_cnt_next = tb_cnt_reg + 12'h001;
        end
      end
      default: begin
        state_next    = EXP_IDLE;
        exposing_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg    <= EXP_IDLE;
      tb_cnt_reg   <= 12'h000;
      units_reg    <= 20'h00000;
      exposing_reg <= 1'b0;
      done_reg     <= 1'b0;
      gain_app_reg <= `GAIN_RESET;
      gain_db_reg  <= 9'h000;
      exp_err_reg  <= 1'b0;
      gain_err_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      tb_cnt_reg   <= tb_cnt_next;
      units_reg    <= units_next;
      exposing_reg <= exposing_next;
      done_reg     <= done_next;
      gain_app_reg <= gain_app_next;
      gain_db_reg  <= gain_db_next;
      exp_err_reg  <= exp_err_next;
      gain_err_reg <= gain_err_next;
    end
  end

  assign exposing_o       = exposing_reg;
  assign exposure_done_o  = done_reg;
  assign gain_applied_o   = gain_app_reg;
  assign gain_db_x10_o    = gain_db_reg;
  assign exp_range_err_o  = exp_err_reg;
  assign gain_range_err_o = gain_err_reg;

  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  logic [31:0] len_cnt;
  logic [31:0] len_want;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      len_cnt  <= 32'h0000_0000;
      len_want <= 32'h0000_0000;
    end else if (state_reg == EXP_IDLE && frame_start_i) begin
      len_cnt  <= 32'h0000_0000;
      len_want <= 32'(exp_eff * mult_eff) * 32'(`TIME_BASE_CYC);
    end else if (exposing_reg) begin
      len_cnt  <= len_cnt + 32'h0000_0001;
    end
  end

  sequence s_rd_feature;
    reg_req_i.rd && (reg_req_i.addr == `EXPOSURE_CONTROL_OFS || reg_req_i.addr == `GAIN_CONTROL_OFS);
  endsequence
  sequence s_start;
    state_reg == EXP_IDLE && frame_start_i;
  endsequence

  property p_present;
    s_rd_feature |=> reg_rvalid_o && reg_rdata_o[`PRESENT_BIT];
  endproperty
  a_present: assert property (p_present) else $error("Present flag not set");
  property p_abs;
    s_rd_feature |=> !reg_rdata_o[`ABS_BIT];
  endproperty
  a_abs: assert property (p_abs) else $error("Absolute flag set");
  property p_one_push;
    s_rd_feature |=> !reg_rdata_o[`ONE_PUSH_BIT];
  endproperty
  a_one_push: assert property (p_one_push) else $error("One push flag set");
  property p_on_off;
    s_rd_feature |=> reg_rdata_o[`ON_OFF_BIT];
  endproperty
  a_on_off: assert property (p_on_off) else $error("On flag clear");
  property p_auto;
    s_rd_feature |=> !reg_rdata_o[`AUTO_BIT];
  endproperty
  a_auto: assert property (p_auto) else $error("Auto flag set");
  property p_reserved;
    s_rd_feature |=> reg_rdata_o[23:12] == 12'h000 && reg_rdata_o[29:27] == 3'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("Reserved bits nonzero");
  property p_exp_len;
    $fell(exposing_o) |-> len_cnt == len_want && exposure_done_o;
  endproperty
  a_exp_len: assert property (p_exp_len) else $error("Exposure length wrong");
  property p_gain_range;
    s_start |=> gain_applied_o >= `GAIN_MIN && gain_applied_o <= $past(gain_max);
  endproperty
  a_gain_range: assert property (p_gain_range) else $error("Gain out of range");
  property p_unity;
    gain_applied_o == `GAIN_MIN |=> gain_db_x10_o == 9'h000;
  endproperty
  a_unity: assert property (p_unity) else $error("Unity gain not 0 dB");
  property p_max_db;
    gain_applied_o == `GAIN_MAX_NARROW |=> gain_db_x10_o == `GAIN_DB_SPAN;
  endproperty
  a_max_db: assert property (p_max_db) else $error("Top gain not 25.9 dB");
  property p_hold;
    exposing_o && state_reg == EXP_RUN |=> $stable(gain_applied_o);
  endproperty
  a_hold: assert property (p_hold) else $error("Gain changed mid exposure");
  property p_write;
    reg_req_i.wr && reg_req_i.addr == `EXPOSURE_CONTROL_OFS |=>
      exp_val_reg == $past(reg_req_i.wdata[11:0]);
  endproperty
  a_write: assert property (p_write) else $error("Exposure write lost");

  property p_gain_write;
    reg_req_i.wr && reg_req_i.addr == `GAIN_CONTROL_OFS |=>
      gain_val_reg == $past(reg_req_i.wdata[11:0]);
  endproperty
  a_gain_write: assert property (p_gain_write) else $error("Gain write lost");
  property p_unmapped;
    reg_req_i.rd && reg_req_i.addr != `EXPOSURE_CONTROL_OFS && reg_req_i.addr != `GAIN_CONTROL_OFS |=>
      reg_rvalid_o && reg_rdata_o == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("Unmapped read not zero");
  property p_exp_err;
    s_start |=>
      exp_range_err_o == ($past(exp_val_reg) == 12'h000);
  endproperty
  a_exp_err: assert property (p_exp_err) else $error("Exposure range flag wrong");
  property p_gain_err;
    s_start |=>
      gain_range_err_o == (gain_applied_o != $past(gain_val_reg));
  endproperty
  a_gain_err: assert property (p_gain_err) else $error("Gain range flag wrong");
  property p_done;
    exposure_done_o |-> !exposing_o && $past(exposing_o);
  endproperty
  a_done: assert property (p_done) else $error("Done without exposure end");

endmodule : exposure_gain_feature_csrs
`default_nettype wire

// [bench/tb.sv]
// Purpose: Self-checking bench for the exposure and gain feature registers
// Assumes: Register port read data lands one cycle after the read strobe
// Notes:   Short exposures only: value 0 to 2 with multiplier 0 to 2 (0 acts as 1)
`timescale 1ns/10ps
`default_nettype none
`include "exposure_gain_consts.svh"

module tb;
  import exposure_gain_pkg::*;

  logic        ref_clk_i;
  logic        rst_i;
  reg_req_t    req;
  logic        fs;
  logic        wide;
  logic [7:0]  mult;
  logic [31:0] rdata;
  logic        rvalid;
  logic        exposing;
  logic        done;
  logic [11:0] gain_app;
  logic [8:0]  gain_db;
  logic        exp_err;
  logic        gain_err;
  int          bad_count;
  int          n_checks;

  exposure_gain_feature_csrs dut_u (
    .ref_clk_i       (ref_clk_i),
    .rst_i           (rst_i),
    .reg_req_i       (req),
    .reg_rdata_o     (rdata),
    .reg_rvalid_o    (rvalid),
    .frame_start_i   (fs),
    .wide_format_i   (wide),
    .tb_mult_i       (mult),
    .exposing_o      (exposing),
    .exposure_done_o (done),
    .gain_applied_o  (gain_app),
    .gain_db_x10_o   (gain_db),
    .exp_range_err_o (exp_err),
    .gain_range_err_o(gain_err)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    if (bad_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge ref_clk_i);
    req <= '0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge ref_clk_i);
    req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 32'h0000_0000};
    @(posedge ref_clk_i);
    req <= '0;
    #1;
    check({31'h0, rvalid}, 32'h0000_0001);
    check(rdata, exp);
  endtask : rd

  // Starts a frame, retriggers and rewrites exposure mid-run, counts cycles
  task automatic frame(input int n_exp, input logic [11:0] mid);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    fs <= 1'b1;
    @(posedge ref_clk_i);
    fs <= 1'b0;
    #1;
    while (exposing === 1'b1 && n < 9000) begin
      n++;
      @(posedge ref_clk_i);
      if (n == 10) begin
        fs  <= 1'b1;
        req <= '{addr: `EXPOSURE_CONTROL_OFS, wr: 1'b1, rd: 1'b0, wdata: {20'h0, mid}};
      end else begin
        fs  <= 1'b0;
        req <= '0;
      end
      #1;
    end
    check(32'(n), 32'(n_exp));
    check({31'h0, done}, 32'h0000_0001);
  endtask : frame

  initial begin
    bad_count = 0;
    n_checks  = 0;
    rst_i     = 1'b1;
    req       = '0;
    fs        = 1'b0;
    wide      = 1'b0;
    mult      = 8'h01;
    repeat (4) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    #1;
    check({20'h0, gain_app}, 32'h0000_0172);
    check({31'h0, exposing}, 32'h0000_0000);
    // Reset values and fixed flags
    rd(`EXPOSURE_CONTROL_OFS, 32'h8200_01f4);
    rd(`GAIN_CONTROL_OFS, 32'h8200_0172);
    // Flags and reserved bits ignore writes
    wr(`EXPOSURE_CONTROL_OFS, 32'hffff_ffff);
    rd(`EXPOSURE_CONTROL_OFS, 32'h8200_0fff);
    wr(`GAIN_CONTROL_OFS, 32'h41f0_015e);
    rd(`GAIN_CONTROL_OFS, 32'h8200_015e);
    wr(12'h900, 32'hffff_ffff);
    rd(12'h900, 32'h0000_0000);
    rd(`EXPOSURE_CONTROL_OFS, 32'h8200_0fff);
    // Exposure length and unity gain
    wr(`EXPOSURE_CONTROL_OFS, 32'h0000_0001);
    frame(2000, 12'h002);
    check({20'h0, gain_app}, 32'h0000_015e);
    check({23'h0, gain_db}, 32'h0000_0000);
    check({31'h0, exp_err}, 32'h0000_0000);
    // Mid-frame write lands on the next exposure only
    frame(4000, 12'h000);
    // Zero exposure value, doubled time base, full narrow gain
    wr(`GAIN_CONTROL_OFS, 32'h0000_03ff);
    mult <= 8'h02;
    frame(4000, 12'h001);
    check({31'h0, exp_err}, 32'h0000_0001);
    check({20'h0, gain_app}, 32'h0000_03ff);
    check({23'h0, gain_db}, 32'h0000_0103);
    check({31'h0, gain_err}, 32'h0000_0000);
    // Wide format clamps gain, zero multiplier acts as one
    @(posedge ref_clk_i);
    wide <= 1'b1;
    mult <= 8'h00;
    frame(2000, 12'h001);
    check({20'h0, gain_app}, 32'h0000_01ff);
    check({31'h0, gain_err}, 32'h0000_0001);
    check({31'h0, exp_err}, 32'h0000_0000);
    rd(`GAIN_CONTROL_OFS, 32'h8200_03ff);
    // Gain below range clamps up to unity
    wr(`GAIN_CONTROL_OFS, 32'h0000_0000);
    frame(2000, 12'h001);
    check({20'h0, gain_app}, 32'h0000_015e);
    check({31'h0, gain_err}, 32'h0000_0001);
    summarize();
  end

  initial begin
    #300us;
    bad_count++;
    summarize();
  end
endmodule : tb
`default_nettype wire
